// [common/iprc_pkg.sv]
/*
  Package for the interrupt priority control registers: offsets, field
  positions, reset values and the bundle of priority outputs.
  Assumes a 16-bit plain register port with word addresses.
*/
package iprc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int PRIO_W = 3;

  // Register word addresses
  localparam logic [3:0] OFS_ADC_TX = 4'h0;
  localparam logic [3:0] OFS_CHG_CMP_TW = 4'h1;

  // Field low-bit positions
  localparam int POS_CONV_DONE = 4;
  localparam int POS_SERIAL_TX = 0;
  localparam int POS_PIN_CHANGE = 12;
  localparam int POS_COMPARATOR = 8;
  localparam int POS_TW_MASTER = 4;
  localparam int POS_TW_SLAVE = 0;

  // Level 4 at power-on reset
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] PRIO_DISABLED = 3'h0;

  typedef struct packed {
    logic [2:0] conv_done_priority;
    logic [2:0] serial_tx_priority;
    logic [2:0] pin_change_priority;
    logic [2:0] comparator_priority;
    logic [2:0] twowire_master_priority;
    logic [2:0] twowire_slave_priority;
  } iprc_prio_type;

endpackage : iprc_pkg

// [rtl/iprc_regs.sv]
/*
  Interrupt priority control registers 3 and 4: six 3-bit priority fields,
  readable and writable over a plain strobe port, each presented as an output.
  Assumes one clock, a synchronous active-low reset and a master that never
  asserts both strobes in one cycle.
*/
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns

// Operation
// - First register bits 15..7 and bit 3 store nothing and read zero.
// - First register bits 6..4 hold conversion-done priority, read/write.
// - First register bits 2..0 hold serial transmitter priority, read/write.
// - Field 7 highest, 1 lowest active, 0 disables that source.
// - Every priority field resets to binary 100, level four.
// - Second register holds four fields; bits 15, 11, 7, 3 read zero.
module iprc_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  output iprc_pkg::iprc_prio_type prio,
  output logic [5:0] src_enabled
);

  iprc_pkg::iprc_prio_type prio_r;
  iprc_pkg::iprc_prio_type prio_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [5:0] en_r;
  logic [5:0] en_nxt;

  always_comb begin
    prio_nxt = prio_r;
    if (wr_stb && addr == iprc_pkg::OFS_ADC_TX) begin
      prio_nxt.conv_done_priority = wdata[iprc_pkg::POS_CONV_DONE +: 3];
      prio_nxt.serial_tx_priority = wdata[iprc_pkg::POS_SERIAL_TX +: 3];
    end
    if (wr_stb && addr == iprc_pkg::OFS_CHG_CMP_TW) begin
      prio_nxt.pin_change_priority = wdata[iprc_pkg::POS_PIN_CHANGE +: 3];
      prio_nxt.comparator_priority = wdata[iprc_pkg::POS_COMPARATOR +: 3];
      prio_nxt.twowire_master_priority = wdata[iprc_pkg::POS_TW_MASTER +: 3];
      prio_nxt.twowire_slave_priority = wdata[iprc_pkg::POS_TW_SLAVE +: 3];
    end
  end

  always_comb begin
    rdata_nxt = 16'h0000;
    if (rd_stb) begin
      case (addr)
        iprc_pkg::OFS_ADC_TX: begin
          rdata_nxt[iprc_pkg::POS_CONV_DONE +: 3] = prio_r.conv_done_priority;
          rdata_nxt[iprc_pkg::POS_SERIAL_TX +: 3] = prio_r.serial_tx_priority;
        end
        iprc_pkg::OFS_CHG_CMP_TW: begin
          rdata_nxt[iprc_pkg::POS_PIN_CHANGE +: 3] = prio_r.pin_change_priority;
          rdata_nxt[iprc_pkg::POS_COMPARATOR +: 3] = prio_r.comparator_priority;
          rdata_nxt[iprc_pkg::POS_TW_MASTER +: 3] = prio_r.twowire_master_priority;
          rdata_nxt[iprc_pkg::POS_TW_SLAVE +: 3] = prio_r.twowire_slave_priority;
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  always_comb begin
    en_nxt[5] = prio_nxt.conv_done_priority != iprc_pkg::PRIO_DISABLED;
    en_nxt[4] = prio_nxt.serial_tx_priority != iprc_pkg::PRIO_DISABLED;
    en_nxt[3] = prio_nxt.pin_change_priority != iprc_pkg::PRIO_DISABLED;
    en_nxt[2] = prio_nxt.comparator_priority != iprc_pkg::PRIO_DISABLED;
    en_nxt[1] = prio_nxt.twowire_master_priority != iprc_pkg::PRIO_DISABLED;
    en_nxt[0] = prio_nxt.twowire_slave_priority != iprc_pkg::PRIO_DISABLED;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prio_r <= {6{iprc_pkg::PRIO_RESET}};
      rdata_r <= 16'h0000;
      en_r <= 6'h3F;
    end else begin
      prio_r <= prio_nxt;
      rdata_r <= rdata_nxt;
      en_r <= en_nxt;
    end
  end

  assign prio = prio_r;
  assign rdata = rdata_r;
  assign src_enabled = en_r;

  AST_WRITE_UPDATES: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_ADC_TX |=> prio.conv_done_priority == $past(wdata[6:4])
      && prio.serial_tx_priority == $past(wdata[2:0]))
    else $error("First register write not applied");
  AST_READ_GAPS_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    rd_stb && addr == iprc_pkg::OFS_ADC_TX |=> rdata[15:7] == 9'h000 && rdata[3] == 1'b0)
    else $error("Unimplemented bits of first register not zero");
  AST_READ_CONV: assert property (@(posedge clk) disable iff (!resetn)
    rd_stb && addr == iprc_pkg::OFS_ADC_TX |=> rdata[6:4] == $past(prio.conv_done_priority))
    else $error("Conversion priority read mismatch");
  AST_READ_TX: assert property (@(posedge clk) disable iff (!resetn)
    rd_stb && addr == iprc_pkg::OFS_ADC_TX |=> rdata[2:0] == $past(prio.serial_tx_priority))
    else $error("Transmitter priority read mismatch");
  AST_DISABLE_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    src_enabled[5] == (prio.conv_done_priority != 3'h0))
    else $error("Enable does not follow priority zero");
  AST_RESET_LEVEL: assert property (@(posedge clk)
    !resetn |=> prio == {6{3'h4}} && rdata == 16'h0000)
    else $error("Reset value not level four");
  AST_SECOND_READ: assert property (@(posedge clk) disable iff (!resetn)
    rd_stb && addr == iprc_pkg::OFS_CHG_CMP_TW |=> rdata[15] == 1'b0 && rdata[11] == 1'b0
      && rdata[7] == 1'b0 && rdata[3] == 1'b0
      && rdata[14:12] == $past(prio.pin_change_priority))
    else $error("Second register read wrong");
  AST_HOLD_NO_WRITE: assert property (@(posedge clk) disable iff (!resetn)
    !wr_stb |=> $stable(prio))
    else $error("Priority changed without a write");
  AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (!resetn)
    !rd_stb |=> rdata == 16'h0000)
    else $error("Read data held beyond one cycle");

  COV_WRITE_FIRST: cover property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_ADC_TX ##1 rd_stb && addr == iprc_pkg::OFS_ADC_TX);
  COV_WRITE_SECOND: cover property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_CHG_CMP_TW);
  COV_DISABLE: cover property (@(posedge clk) disable iff (!resetn) src_enabled != 6'h3F);
  COV_READ_SECOND: cover property (@(posedge clk) disable iff (!resetn)
    rd_stb && addr == iprc_pkg::OFS_CHG_CMP_TW);
  COV_LEVEL_SEVEN: cover property (@(posedge clk) disable iff (!resetn)
    prio.conv_done_priority == 3'h7);

  AST_WRITE_PIN: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_CHG_CMP_TW
    |=> prio.pin_change_priority == $past(wdata[14:12]))
    else $error("Input change priority write not applied");

  AST_WRITE_CMP: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_CHG_CMP_TW
    |=> prio.comparator_priority == $past(wdata[10:8]))
    else $error("Comparator priority write not applied");

  AST_WRITE_MASTER: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_CHG_CMP_TW
    |=> prio.twowire_master_priority == $past(wdata[6:4]))
    else $error("Bus master priority write not applied");

  AST_WRITE_SLAVE: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_CHG_CMP_TW
    |=> prio.twowire_slave_priority == $past(wdata[2:0]))
    else $error("Bus slave priority write not applied");

  AST_READ_CMP: assert property (@(posedge clk) disable iff (!resetn)
    rd_stb && addr == iprc_pkg::OFS_CHG_CMP_TW
    |=> rdata[10:8] == $past(prio.comparator_priority))
    else $error("Comparator priority read mismatch");

  AST_READ_MASTER: assert property (@(posedge clk) disable iff (!resetn)
    rd_stb && addr == iprc_pkg::OFS_CHG_CMP_TW
    |=> rdata[6:4] == $past(prio.twowire_master_priority))
    else $error("Bus master priority read mismatch");

  AST_READ_SLAVE: assert property (@(posedge clk) disable iff (!resetn)
    rd_stb && addr == iprc_pkg::OFS_CHG_CMP_TW
    |=> rdata[2:0] == $past(prio.twowire_slave_priority))
    else $error("Bus slave priority read mismatch");

  AST_DISABLE_TX: assert property (@(posedge clk) disable iff (!resetn)
    src_enabled[4] == (prio.serial_tx_priority != 3'h0))
    else $error("Transmitter enable does not follow priority zero");

  AST_DISABLE_PIN: assert property (@(posedge clk) disable iff (!resetn)
    src_enabled[3] == (prio.pin_change_priority != 3'h0))
    else $error("Input change enable does not follow priority zero");

  AST_DISABLE_CMP: assert property (@(posedge clk) disable iff (!resetn)
    src_enabled[2] == (prio.comparator_priority != 3'h0))
    else $error("Comparator enable does not follow priority zero");

  AST_DISABLE_MASTER: assert property (@(posedge clk) disable iff (!resetn)
    src_enabled[1] == (prio.twowire_master_priority != 3'h0))
    else $error("Bus master enable does not follow priority zero");

  AST_DISABLE_SLAVE: assert property (@(posedge clk) disable iff (!resetn)
    src_enabled[0] == (prio.twowire_slave_priority != 3'h0))
    else $error("Bus slave enable does not follow priority zero");

  AST_LEVEL_SEVEN_ON: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_ADC_TX && wdata[6:4] == 3'h7
    |=> src_enabled[5])
    else $error("Level seven left source disabled");

  AST_FIRST_KEEPS_SECOND: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_ADC_TX
    |=> $stable(prio[11:0]))
    else $error("First register write disturbed second register");

  AST_SECOND_KEEPS_FIRST: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_CHG_CMP_TW
    |=> $stable(prio[17:12]))
    else $error("Second register write disturbed first register");

  AST_UNMAPPED_WRITE: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr != iprc_pkg::OFS_ADC_TX && addr != iprc_pkg::OFS_CHG_CMP_TW
    |=> $stable(prio))
    else $error("Unmapped write changed a priority");

  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!resetn)
    rd_stb && addr != iprc_pkg::OFS_ADC_TX && addr != iprc_pkg::OFS_CHG_CMP_TW
    |=> rdata == 16'h0000)
    else $error("Unmapped read not zero");

  AST_RESET_ENABLES: assert property (@(posedge clk)
    !resetn |=> src_enabled == 6'h3F)
    else $error("Source enables not set after reset");

  AST_ENABLE_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    !wr_stb |=> $stable(src_enabled))
    else $error("Source enable changed without a write");

  AST_READ_KEEPS_PRIO: assert property (@(posedge clk) disable iff (!resetn)
    rd_stb |=> $stable(prio))
    else $error("Read disturbed a priority");

  AST_READ_KEEPS_EN: assert property (@(posedge clk) disable iff (!resetn)
    rd_stb |=> $stable(src_enabled))
    else $error("Read disturbed a source enable");

  AST_FIRST_KEEPS_EN: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_ADC_TX
    |=> $stable(src_enabled[3:0]))
    else $error("First register write disturbed second enables");

  AST_SECOND_KEEPS_EN: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_CHG_CMP_TW
    |=> $stable(src_enabled[5:4]))
    else $error("Second register write disturbed first enables");

  AST_FIRST_ROUND_TRIP: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_ADC_TX ##1 rd_stb && addr == iprc_pkg::OFS_ADC_TX
    |=> rdata[6:4] == $past(wdata[6:4], 2))
    else $error("Conversion priority round trip mismatch");

  AST_SECOND_ROUND_TRIP: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_CHG_CMP_TW ##1 rd_stb && addr == iprc_pkg::OFS_CHG_CMP_TW
    |=> rdata[14:12] == $past(wdata[14:12], 2))
    else $error("Input change priority round trip mismatch");

  AST_TX_ROUND_TRIP: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb && addr == iprc_pkg::OFS_ADC_TX ##1 rd_stb && addr == iprc_pkg::OFS_ADC_TX
    |=> rdata[2:0] == $past(wdata[2:0], 2))
    else $error("Transmitter priority round trip mismatch");

endmodule : iprc_regs

// [sim/tb.sv]
/*
  Bench for the priority registers: strobe-port accesses, checks of read
  data, priority outputs and source enables.
  Assumes the package is compiled first and one 100 MHz clock.
*/
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("FAIL %s expected %h seen %h", n, e, a); end end
module tb;
  logic clk, resetn, wr_stb, rd_stb;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  iprc_pkg::iprc_prio_type prio;
  logic [5:0] src_enabled;
  int num_errors = 0;
  int checks_done = 0;
  iprc_regs iprc_regs_i (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .prio(prio),
    .src_enabled(src_enabled));
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    num_errors++;
    report_and_stop();
  end
  task automatic test_reset;
    @(posedge clk);
    resetn <= 1'h0;
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    #1;
    `CHK("prio", {6{3'h4}}, prio)
    `CHK("enables", 6'h3F, src_enabled)
    rd(4'h0, 16'h0044);
    rd(4'h1, 16'h4444);
    $display("test reset done");
  endtask : test_reset
  task automatic test_first;
    wr(4'h0, 16'hFFFF);
    `CHK("conv", 3'h7, prio.conv_done_priority)
    `CHK("tx", 3'h7, prio.serial_tx_priority)
    rd(4'h0, 16'h0077);
    @(posedge clk);
    #1;
    `CHK("rdata idle", 16'h0000, rdata)
    wr(4'h0, 16'h0010);
    `CHK("conv", 3'h1, prio.conv_done_priority)
    `CHK("enables", 6'h2F, src_enabled)
    $display("test first register done");
  endtask : test_first
  task automatic test_second;
    wr(4'h1, 16'hFFFF);
    rd(4'h1, 16'h7777);
    wr(4'h1, 16'h1234);
    `CHK("second", {3'h1, 3'h2, 3'h3, 3'h4}, prio[11:0])
    wr(4'h1, 16'h0000);
    `CHK("enables", 6'h20, src_enabled)
    $display("test second register done");
  endtask : test_second
  task automatic test_unmapped;
    wr(4'h2, 16'hFFFF);
    rd(4'h2, 16'h0000);
    rd(4'h0, 16'h0010);
    rd(4'h1, 16'h0000);
    $display("test unmapped done");
  endtask : test_unmapped
  initial begin
    resetn = 1'h0;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
    addr = 4'h0;
    wdata = 16'h0000;
    test_reset();
    test_first();
    test_second();
    test_unmapped();
    test_reset();
    report_and_stop();
  end
endmodule : tb
